// [common/ctbu_consts.svh]
// Constants for the clear-test branch unit
// Summary of operation
// RULE1 - The bit-clear branch is decoded from opcode 30h as three bytes (opcode, bit address, displacement) and finishes in two machine cycles.
// RULE2 - The bit-clear branch first moves the program counter on by three, then adds the displacement only if the addressed bit is zero.
// RULE3 - The bit-clear branch never writes the addressed bit.
// RULE4 - The bit-clear branch never writes any status flag, carry included.
// RULE5 - The carry-clear branch is decoded from opcode 50h as two bytes (opcode, displacement) and finishes in two machine cycles.
// RULE6 - The carry-clear branch moves the program counter on by two, then adds the displacement only if carry is zero.
// RULE7 - The carry-clear branch leaves the carry flag as it was.
// RULE8 - The displacement is sign-extended and the sum wraps modulo the program counter range.
`ifndef CTBU_CONSTS_SVH
`define CTBU_CONSTS_SVH
`define CTBU_OP_BIT_CLEAR   8'h30
`define CTBU_OP_CARRY_CLEAR 8'h50
`define CTBU_LEN_BIT_CLEAR  16'h0003
`define CTBU_LEN_CARRY_CLR  16'h0002
`define CTBU_MACHINE_CYCLES 2
`define CTBU_PC_RESET       16'h0000
`endif

// [common/ctbu_pkg.sv]
// Types for the clear-test branch unit
package ctbu_pkg;
    typedef enum logic [3:0] {
        CTBU_IDLE = 4'b0001,
        CTBU_BITA = 4'b0010,
        CTBU_DISP = 4'b0100,
        CTBU_EXEC = 4'b1000
    } ctbu_state_t;
endpackage

// [logic/ctbu_target.sv]
// Branch target adder with sign extension
`timescale 1ns/10ps
`include "ctbu_consts.svh"
module ctbu_target (
    input  wire logic [15:0] pc_in,
    input  wire logic [15:0] length,
    input  wire logic [7:0]  disp,
    input  wire logic        take,
    output logic      [15:0] pc_out
);
    logic [15:0] seq_pc;
    // Sequential address first, then the optional relative offset
    // RULE2 step past instruction
    assign seq_pc = pc_in + length;
    // RULE8 sign extend and wrap
    assign pc_out = take ? seq_pc + {{8{disp[7]}}, disp} : seq_pc;
endmodule

// [logic/ctbu_unit.sv]
// Execution of the bit-clear and carry-clear relative branches
`timescale 1ns/10ps
`include "ctbu_consts.svh"
module ctbu_unit (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_data,
    input  wire logic [15:0] pc_start,
    input  wire logic        bit_value,
    input  wire logic        carry_in,
    output logic             busy,
    output logic             bit_addr_valid,
    output logic      [7:0]  bit_addr,
    output logic             pc_load,
    output logic      [15:0] program_counter,
    output logic             branch_taken,
    output logic             carry_out,
    output logic             bit_write_en,
    output logic             flag_write_en
);
    ctbu_pkg::ctbu_state_t state_reg;
    logic        is_bit_reg;
    logic [15:0] pc_base_reg;
    logic [7:0]  disp_reg;
    logic        cycle_reg;
    logic        take_next;
    logic [15:0] target_next;

    // Opcode recognition, shared by operand capture, the busy flag and the foreign-opcode check
    function automatic logic ctbu_is_branch_op(input logic [7:0] b);
        return (b == `CTBU_OP_BIT_CLEAR) || (b == `CTBU_OP_CARRY_CLEAR);
    endfunction

    // Instruction length in bytes, which is also the sequential step
    function automatic logic [15:0] ctbu_instr_len(input logic is_bit);
        return is_bit ? `CTBU_LEN_BIT_CLEAR : `CTBU_LEN_CARRY_CLR;
    endfunction

    // Displacement widened to the counter width with its sign kept, for the checks
    function automatic logic [15:0] ctbu_sext(input logic [7:0] d);
        return {{8{d[7]}}, d};
    endfunction

    // Taken condition: addressed bit zero or carry zero
    // The operand is read live in the last execute cycle, so the core must hold it steady there
    assign take_next = is_bit_reg ? ~bit_value : ~carry_in;

    // Adder kept apart so the sequential and taken targets share one sum
    ctbu_target ctbu_target_inst (
        .pc_in  (pc_base_reg),
        .length (ctbu_instr_len(is_bit_reg)),
        .disp   (disp_reg),
        .take   (take_next),
        .pc_out (target_next)
    );

    // Byte collection sequence; unknown opcodes are ignored
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ctbu_pkg::CTBU_IDLE;
        end else begin
            case (state_reg)
                ctbu_pkg::CTBU_IDLE: begin
                    // RULE1 bit-clear decode
                    if (byte_valid && byte_data == `CTBU_OP_BIT_CLEAR) begin
                        state_reg <= ctbu_pkg::CTBU_BITA;
                    // RULE5 carry-clear decode
                    end else if (byte_valid && byte_data == `CTBU_OP_CARRY_CLEAR) begin
                        state_reg <= ctbu_pkg::CTBU_DISP;
                    end
                end
                ctbu_pkg::CTBU_BITA: if (byte_valid) begin
                    state_reg <= ctbu_pkg::CTBU_DISP;
                end
                ctbu_pkg::CTBU_DISP: if (byte_valid) begin
                    state_reg <= ctbu_pkg::CTBU_EXEC;
                end
                // Bytes offered while executing are dropped, so the core waits for busy to fall
                ctbu_pkg::CTBU_EXEC: if (cycle_reg) begin
                    state_reg <= ctbu_pkg::CTBU_IDLE;
                end
                default: state_reg <= ctbu_pkg::CTBU_IDLE;
            endcase
        end
    end

    // Operand capture; base address latched with the opcode
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            is_bit_reg  <= 1'b0;
            pc_base_reg <= `CTBU_PC_RESET;
            disp_reg    <= 8'h00;
            bit_addr    <= 8'h00;
        end else begin
            // Only a recognised opcode moves the base, so a foreign byte leaves no trace
            if (state_reg == ctbu_pkg::CTBU_IDLE && byte_valid && ctbu_is_branch_op(byte_data)) begin
                is_bit_reg  <= (byte_data == `CTBU_OP_BIT_CLEAR);
                pc_base_reg <= pc_start;
            end
            // The bit address stays put for the core's bit read until the next bit-clear
            if (state_reg == ctbu_pkg::CTBU_BITA && byte_valid) begin
                bit_addr <= byte_data;
            end
            if (state_reg == ctbu_pkg::CTBU_DISP && byte_valid) begin
                disp_reg <= byte_data;
            end
        end
    end

    // Two execute cycles stand for the two machine cycles of either branch
    // RULE1 RULE5 two machine cycles
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cycle_reg <= 1'b0;
        end else begin
            cycle_reg <= (state_reg == ctbu_pkg::CTBU_EXEC) && !cycle_reg;
        end
    end

    // Status outputs
    // busy rises at the edge that takes the opcode, so the fetch side can pause at once
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            busy           <= 1'b0;
            bit_addr_valid <= 1'b0;
        end else begin
            busy           <= (state_reg != ctbu_pkg::CTBU_IDLE) || (byte_valid && ctbu_is_branch_op(byte_data));
            bit_addr_valid <= (state_reg == ctbu_pkg::CTBU_BITA) && byte_valid;
        end
    end

    // Program counter update at the end of the second execute cycle
    // The load strobe drops by default every cycle, so the core sees exactly one pulse
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pc_load         <= 1'b0;
            program_counter <= `CTBU_PC_RESET;
            branch_taken    <= 1'b0;
        end else begin
            pc_load      <= 1'b0;
            branch_taken <= 1'b0;
            if (state_reg == ctbu_pkg::CTBU_EXEC && cycle_reg) begin
                // RULE2 condition and target
                // RULE6 condition and target
                pc_load         <= 1'b1;
                program_counter <= target_next;
                branch_taken    <= take_next;
            end
        end
    end

    // Neither branch ever writes the tested bit or a flag; carry passes through
    // The write enables exist only so the core's write paths are visibly tied off
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bit_write_en  <= 1'b0;
            flag_write_en <= 1'b0;
            carry_out     <= 1'b0;
        end else begin
            // RULE3 bit untouched
            bit_write_en  <= 1'b0;
            // RULE4 flags untouched
            flag_write_en <= 1'b0;
            // RULE7 carry preserved
            carry_out     <= carry_in;
        end
    end

    // Checks
    logic [15:0] exp_seq;
    assign exp_seq = pc_base_reg + ctbu_instr_len(is_bit_reg);

    // Decode and operand capture
    bit_opcode_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE1
        (state_reg == ctbu_pkg::CTBU_IDLE && byte_valid && byte_data == `CTBU_OP_BIT_CLEAR)
        |=> state_reg == ctbu_pkg::CTBU_BITA) else $error("bit-clear opcode not decoded");
    carry_opcode_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE5
        (state_reg == ctbu_pkg::CTBU_IDLE && byte_valid && byte_data == `CTBU_OP_CARRY_CLEAR)
        |=> state_reg == ctbu_pkg::CTBU_DISP) else $error("carry-clear opcode not decoded");
    addr_capture_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE1
        (state_reg == ctbu_pkg::CTBU_BITA && byte_valid)
        |=> bit_addr_valid && bit_addr == $past(byte_data)) else $error("bit address not captured");
    foreign_ignored_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE5
        (state_reg == ctbu_pkg::CTBU_IDLE && byte_valid && !ctbu_is_branch_op(byte_data))
        |=> state_reg == ctbu_pkg::CTBU_IDLE) else $error("foreign opcode accepted");

    // Timing of the two execute cycles and the load pulse
    exec_length_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE1
        $rose(state_reg == ctbu_pkg::CTBU_EXEC) |-> ##2 pc_load) else $error("execute not two cycles");
    load_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE6
        pc_load |=> !pc_load) else $error("load strobe held too long");

    // Target arithmetic on both outcomes of both forms
    bit_not_taken_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE2
        (state_reg == ctbu_pkg::CTBU_EXEC && cycle_reg && is_bit_reg && bit_value)
        |=> program_counter == $past(exp_seq) && !branch_taken) else $error("bit-clear wrong fallthrough");
    bit_taken_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE2
        (state_reg == ctbu_pkg::CTBU_EXEC && cycle_reg && is_bit_reg && !bit_value)
        |=> program_counter == $past(exp_seq) + ctbu_sext($past(disp_reg)) && branch_taken)
        else $error("bit-clear wrong target");
    carry_taken_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE6
        (state_reg == ctbu_pkg::CTBU_EXEC && cycle_reg && !is_bit_reg && !carry_in)
        |=> program_counter == $past(exp_seq) + ctbu_sext($past(disp_reg)))
        else $error("carry-clear wrong target");
    carry_not_taken_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE6
        (state_reg == ctbu_pkg::CTBU_EXEC && cycle_reg && !is_bit_reg && carry_in)
        |=> program_counter == $past(exp_seq) && !branch_taken) else $error("carry-clear wrong fallthrough");
    sign_wrap_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE8
        (pc_load && branch_taken) |-> program_counter - $past(exp_seq, 1) == ctbu_sext($past(disp_reg)))
        else $error("displacement not sign-extended");

    // Side effects: nothing written back, carry passed through untouched
    bit_kept_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE3
        busy |-> !bit_write_en) else $error("tested bit written");
    flags_kept_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE4
        busy |-> !flag_write_en) else $error("flag written");
    carry_kept_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE7
        ##1 carry_out == $past(carry_in)) else $error("carry changed");

    // Main scenarios: each outcome of each form and a backward jump
    cover property (@(posedge mclk) disable iff (!rst_b) pc_load && !branch_taken && !is_bit_reg);
    cover property (@(posedge mclk) disable iff (!rst_b) pc_load && branch_taken && is_bit_reg);
    cover property (@(posedge mclk) disable iff (!rst_b) pc_load && !branch_taken && is_bit_reg);
    cover property (@(posedge mclk) disable iff (!rst_b) pc_load && branch_taken && !is_bit_reg);
    cover property (@(posedge mclk) disable iff (!rst_b) pc_load && branch_taken && disp_reg[7]);
endmodule

// [test/ctbu_fetch_model.sv]
// Behavioural model of the core fetch path that feeds instruction bytes
`timescale 1ns/10ps
module ctbu_fetch_model (
    input  wire logic       mclk,
    output logic            byte_valid,
    output logic      [7:0] byte_data
);
    // Bus starts idle
    initial begin
        byte_valid = 1'b0;
        byte_data  = 8'h00;
    end

    // Present one byte at the falling edge, hold it across the sampling edge
    task automatic send_byte(input logic [7:0] b);
        byte_valid = 1'b1;
        byte_data  = b;
        @(negedge mclk);
    endtask

    // Idle data is inverted so a stale byte can never be taken by luck
    task automatic release_bus();
        byte_valid = 1'b0;
        byte_data  = ~byte_data;
    endtask
endmodule

// [test/tb_clear_test_branch_unit.sv]
// Self-checking bench for the clear-test branch unit
`timescale 1ns/10ps
module tb_clear_test_branch_unit;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic byte_valid, bit_value = 1'b0, carry_in = 1'b0, busy, bit_addr_valid, pc_load;
    logic branch_taken, carry_out, bit_write_en, flag_write_en;
    logic [7:0] byte_data, bit_addr;
    logic [15:0] pc_start = 16'h0000, program_counter;
    int errors = 0;
    int n_compared = 0;

    ctbu_fetch_model ctbu_fetch_model_inst (.mclk(mclk), .byte_valid(byte_valid), .byte_data(byte_data));
    ctbu_unit ctbu_unit_inst (.mclk(mclk), .rst_b(rst_b), .byte_valid(byte_valid), .byte_data(byte_data),
        .pc_start(pc_start), .bit_value(bit_value), .carry_in(carry_in), .busy(busy),
        .bit_addr_valid(bit_addr_valid), .bit_addr(bit_addr), .pc_load(pc_load),
        .program_counter(program_counter), .branch_taken(branch_taken), .carry_out(carry_out),
        .bit_write_en(bit_write_en), .flag_write_en(flag_write_en));

    // 10 MHz core clock
    always #50 mclk = ~mclk;

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        if (errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // One branch; cond is the tested bit or carry, which also decides taken
    task automatic exec_branch(input logic [7:0] op, input logic [7:0] ba, input logic [7:0] d,
        input logic cond, input logic [15:0] pc);
        logic [15:0] exp;
        int n;
        exp = pc + ((op == 8'h30) ? 16'h0003 : 16'h0002) + (!cond ? {{8{d[7]}}, d} : 16'h0000);
        @(negedge mclk);
        pc_start = pc;
        // The unused operand gets the opposite value, so testing the wrong one shows up
        bit_value = (op == 8'h30) ? cond : ~cond;
        carry_in = (op == 8'h30) ? ~cond : cond;
        ctbu_fetch_model_inst.send_byte(op);
        if (op == 8'h30) begin
            ctbu_fetch_model_inst.send_byte(ba);
            chk("bit_addr_valid", 16'h0001, {15'h0, bit_addr_valid});
        end
        ctbu_fetch_model_inst.send_byte(d);
        ctbu_fetch_model_inst.release_bus();
        n = 0;
        while (pc_load !== 1'b1 && n < 10) begin
            @(negedge mclk);
            n++;
        end
        chk("pc_load", 16'h0001, {15'h0, pc_load});
        chk("load_latency", 16'h0002, n[15:0]);
        chk("program_counter", exp, program_counter);
        chk("branch_taken", {15'h0, !cond}, {15'h0, branch_taken});
        if (op == 8'h30) chk("bit_addr", {8'h0, ba}, {8'h0, bit_addr});
        chk("write_enables", 16'h0, {14'h0, bit_write_en, flag_write_en});
        chk("carry_out", {15'h0, carry_in}, {15'h0, carry_out});
        @(negedge mclk);
        chk("busy", 16'h0, {15'h0, busy});
    endtask

    task automatic t_bit_clear_taken();
        exec_branch(8'h30, 8'h2b, 8'h10, 1'b0, 16'h1000);
    endtask

    task automatic t_bit_set_falls_through();
        exec_branch(8'h30, 8'hd7, 8'h80, 1'b1, 16'h2ffd);
    endtask

    task automatic t_carry_clear_wraps_up();
        exec_branch(8'h50, 8'h00, 8'h7f, 1'b0, 16'hfffe);
    endtask

    task automatic t_carry_set_falls_through();
        exec_branch(8'h50, 8'h00, 8'hf0, 1'b1, 16'h0400);
    endtask

    task automatic t_negative_wraps_down();
        exec_branch(8'h50, 8'h00, 8'h80, 1'b0, 16'h0005);
    endtask

    // An opcode of another branch must not start anything
    task automatic t_foreign_opcode();
        @(negedge mclk);
        ctbu_fetch_model_inst.send_byte(8'h20);
        ctbu_fetch_model_inst.send_byte(8'h05);
        ctbu_fetch_model_inst.release_bus();
        repeat (4) @(negedge mclk);
        chk("idle_outputs", 16'h0, {14'h0, busy, pc_load});
    endtask

    // Reset in mid-instruction drops everything and leaves the unit ready for the next one
    task automatic t_reset_mid_branch();
        @(negedge mclk);
        ctbu_fetch_model_inst.send_byte(8'h50);
        ctbu_fetch_model_inst.release_bus();
        rst_b = 1'b0;
        @(negedge mclk);
        chk("reset_outputs", 16'h0, {13'h0, busy, pc_load, bit_addr_valid});
        chk("reset_counter", 16'h0000, program_counter);
        rst_b = 1'b1;
        exec_branch(8'h50, 8'h00, 8'h03, 1'b0, 16'h0100);
    endtask

    // Budget is generous against roughly fifty cycles of traffic
    initial begin
        #50000;
        errors++;
        close_out();
    end

    initial begin
        repeat (3) @(negedge mclk);
        rst_b = 1'b1;
        t_bit_clear_taken();
        t_bit_set_falls_through();
        t_carry_clear_wraps_up();
        t_carry_set_falls_through();
        t_negative_wraps_down();
        t_reset_mid_branch();
        t_foreign_opcode();
        close_out();
    end
endmodule
